// >>> hdl/cpu_slice_defines.svh
`ifndef CPU_SLICE_DEFINES_SVH
`define CPU_SLICE_DEFINES_SVH

// ----------------------------------------------
// Opcodes
// ----------------------------------------------
`define OP_PREFIX   8'h18
`define OP_TEST     8'h00
`define OP_TAP      8'h06
`define OP_TPA      8'h07
`define OP_TSX      8'h30
`define OP_TXS      8'h35
`define OP_WAI      8'h3E
`define OP_ACC_A_SIGN_ZERO_CHECK     8'h4D
`define OP_ACC_B_SIGN_ZERO_CHECK     8'h5D
`define OP_TST_IDX  8'h6D
`define OP_TST_EXT  8'h7D
`define LO_SUB8     4'h0
`define LO_SUB16    4'h3
`define HI_SUB16    2'h2

// ----------------------------------------------
// Flag bit positions and reset values
// ----------------------------------------------
`define CC_C        0
`define CC_V        1
`define CC_Z        2
`define CC_N        3
`define CC_X        6
`define CC_X_MASK   8'h40
`define CCR_RST     8'hD0
`define PC_RST      16'h0000
`define SP_RST      16'h00FF

// ----------------------------------------------
// Cycle counts
// ----------------------------------------------
`define CYC_IMM       5'h02
`define CYC_DIR       5'h03
`define CYC_EXT       5'h04
`define CYC_IDX       5'h04
`define CYC_WORD      5'h02
`define CYC_TST       5'h06
`define CYC_INH       5'h02
`define CYC_XFER      5'h03
`define CYC_WAI_STACK 5'h0C
`define WAI_PUSHES    5'h09

`endif

// >>> hdl/cpu_subtract_test_transfer_ops.sv
`timescale 1ns/100ps
`include "cpu_slice_defines.svh"
module cpu_subtract_test_transfer_ops (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  MEM_RDATA,
  input  wire logic        TEST_MODE,
  input  wire logic        IRQ_PEND,
  input  wire logic [15:0] IRQ_VECTOR,
  output cs_pkg::mem_req_s MEM_REQ,
  output cs_pkg::regs_s    REGS,
  output logic             WAITING,
  output logic [15:0]      REL_TARGET
);

  // ----------------------------------------------
  // Decode helpers
  // ----------------------------------------------
  function automatic cs_pkg::dec_s decode(input logic [7:0] op, input logic pre,
                                          input logic tm);
    cs_pkg::dec_s d;
    d.mode = cs_pkg::mode_e'(op[5:4]);
    d.kind = cs_pkg::K_NOP;
    if (op[3:0] == `LO_SUB8 && op[7])
      d.kind = op[6] ? cs_pkg::K_SUB_MEM_FROM_ACC_B : cs_pkg::K_SUB_MEM_FROM_ACC_A;
    else if (op[3:0] == `LO_SUB16 && op[7:6] == `HI_SUB16)
      d.kind = cs_pkg::K_SUB_WORD_FROM_DOUBLE_ACC;
    else
    begin
      case (op)
        `OP_TST_EXT, `OP_TST_IDX: d.kind = cs_pkg::K_TST;
        `OP_ACC_A_SIGN_ZERO_CHECK:                 d.kind = cs_pkg::K_ACC_A_SIGN_ZERO_CHECK;
        `OP_ACC_B_SIGN_ZERO_CHECK:                 d.kind = cs_pkg::K_ACC_B_SIGN_ZERO_CHECK;
        `OP_TAP:                  d.kind = cs_pkg::K_TAP;
        `OP_TPA:                  d.kind = cs_pkg::K_TPA;
        `OP_TSX:                  d.kind = cs_pkg::K_TSX;
        `OP_TXS:                  d.kind = cs_pkg::K_TXS;
        `OP_WAI:                  d.kind = cs_pkg::K_WAI;
        `OP_TEST:                 d.kind = tm ? cs_pkg::K_TEST : cs_pkg::K_NOP;
        default:                  d.kind = cs_pkg::K_NOP;
      endcase
    end
    case (d.kind)
      cs_pkg::K_SUB_MEM_FROM_ACC_A, cs_pkg::K_SUB_MEM_FROM_ACC_B, cs_pkg::K_SUB_WORD_FROM_DOUBLE_ACC:
        d.tot = (d.mode == cs_pkg::M_IMM) ? `CYC_IMM :
                (d.mode == cs_pkg::M_DIR) ? `CYC_DIR :
                (d.mode == cs_pkg::M_IDX) ? `CYC_IDX : `CYC_EXT;
      cs_pkg::K_TST:                  d.tot = `CYC_TST;
      cs_pkg::K_TSX, cs_pkg::K_TXS:   d.tot = `CYC_XFER;
      default:                        d.tot = `CYC_INH;
    endcase
    if (d.kind == cs_pkg::K_SUB_WORD_FROM_DOUBLE_ACC)
      d.tot = d.tot + `CYC_WORD;
    d.tot = d.tot + {4'h0, pre};
    return d;
  endfunction

  function automatic logic is_mem(input cs_pkg::kind_e k);
    return k inside {cs_pkg::K_SUB_MEM_FROM_ACC_A, cs_pkg::K_SUB_MEM_FROM_ACC_B, cs_pkg::K_SUB_WORD_FROM_DOUBLE_ACC, cs_pkg::K_TST};
  endfunction

  // Target of a signed offset, from the byte after it
  function automatic logic [15:0] rel_target(input logic [15:0] nxt, input logic [7:0] off);
    return nxt + {{8{off[7]}}, off};
  endfunction

  // Push order on wait: PC, Y, X low byte first, then A, B, flags
  function automatic logic [7:0] push_byte(input logic [3:0] i, input cs_pkg::regs_s r);
    case (i)
      4'h0:    return r.pc[7:0];
      4'h1:    return r.pc[15:8];
      4'h2:    return r.y[7:0];
      4'h3:    return r.y[15:8];
      4'h4:    return r.x[7:0];
      4'h5:    return r.x[15:8];
      4'h6:    return r.a;
      4'h7:    return r.b;
      default: return r.flag_register;
    endcase
  endfunction

  // ----------------------------------------------
  // Datapath
  // ----------------------------------------------
  cs_pkg::core_s   s;
  cs_pkg::core_s   n;
  cs_pkg::dec_s    dec_now;
  cs_pkg::alu_op_e alu_op;
  logic [15:0]     ixb;
  logic [15:0]     opnd;
  logic [15:0]     alu_lhs;
  logic [15:0]     alu_res;
  logic [7:0]      alu_ccr;
  logic            fin;

  assign dec_now = decode(MEM_RDATA, s.pre, TEST_MODE);
  assign ixb     = s.pre ? s.r.y : s.r.x;
  // Low byte read in the final cycle is used live
  assign opnd    = {s.dat[15:8], (s.st == cs_pkg::ST_DATA) ? MEM_RDATA : s.dat[7:0]};
  assign fin     = (s.st inside {cs_pkg::ST_ADDR, cs_pkg::ST_DATA, cs_pkg::ST_PAD})
                   && (s.cnt == s.dec.tot - 5'h01);

  assign alu_op  = (s.dec.kind == cs_pkg::K_SUB_WORD_FROM_DOUBLE_ACC) ? cs_pkg::ALU_SUB16 :
                   (s.dec.kind inside {cs_pkg::K_TST, cs_pkg::K_ACC_A_SIGN_ZERO_CHECK, cs_pkg::K_ACC_B_SIGN_ZERO_CHECK}) ?
                   cs_pkg::ALU_TEST8 : cs_pkg::ALU_SUB8;
  assign alu_lhs = (s.dec.kind == cs_pkg::K_SUB_WORD_FROM_DOUBLE_ACC) ? {s.r.a, s.r.b} :
                   (s.dec.kind inside {cs_pkg::K_SUB_MEM_FROM_ACC_B, cs_pkg::K_ACC_B_SIGN_ZERO_CHECK}) ? {8'h00, s.r.b} :
                   (s.dec.kind == cs_pkg::K_TST) ? {8'h00, opnd[7:0]} : {8'h00, s.r.a};

  sub_test_alu u_alu (
    .op      (alu_op),
    .lhs     (alu_lhs),
    .rhs     (opnd),
    .ccr_in  (s.r.flag_register),
    .res     (alu_res),
    .ccr_out (alu_ccr)
  );

  // ----------------------------------------------
  // Sequencer
  // ----------------------------------------------
  always_comb
  begin
    n     = s;
    n.cnt = s.cnt + 5'h01;
    unique case (s.st)
      cs_pkg::ST_FETCH:
      begin
        n.r.pc = s.r.pc + 16'h0001;
        if (MEM_RDATA == `OP_PREFIX && !s.pre)
          n.pre = 1'h1;
        else
        begin
          n.dec = dec_now;
          n.bi  = 1'h0;
          if (dec_now.kind == cs_pkg::K_WAI)
            n.st = cs_pkg::ST_STACK;
          else if (dec_now.kind == cs_pkg::K_TEST)
            n.st = cs_pkg::ST_TEST;
          else if (!is_mem(dec_now.kind))
            n.st = cs_pkg::ST_PAD;
          else if (dec_now.mode == cs_pkg::M_IMM)
            n.st = cs_pkg::ST_DATA;
          else
            n.st = cs_pkg::ST_ADDR;
        end
      end
      cs_pkg::ST_ADDR:
      begin
        n.r.pc = s.r.pc + 16'h0001;
        n.btgt = rel_target(n.r.pc, MEM_RDATA);
        unique case (s.dec.mode)
          cs_pkg::M_DIR:
          begin
            n.ea = {8'h00, MEM_RDATA};
            n.st = cs_pkg::ST_DATA;
          end
          cs_pkg::M_IDX:
          begin
            n.ea = ixb + {8'h00, MEM_RDATA};
            n.st = cs_pkg::ST_DATA;
          end
          default:
          begin
            if (!s.bi)
            begin
              n.ea[15:8] = MEM_RDATA;
              n.bi       = 1'h1;
            end
            else
            begin
              n.ea[7:0] = MEM_RDATA;
              n.bi      = 1'h0;
              n.st      = cs_pkg::ST_DATA;
            end
          end
        endcase
      end
      cs_pkg::ST_DATA:
      begin
        if (s.dec.mode == cs_pkg::M_IMM)
          n.r.pc = s.r.pc + 16'h0001;
        if (s.dec.kind == cs_pkg::K_SUB_WORD_FROM_DOUBLE_ACC && !s.bi)
        begin
          n.dat[15:8] = MEM_RDATA;
          n.bi        = 1'h1;
        end
        else
        begin
          n.dat[7:0] = MEM_RDATA;
          n.st       = cs_pkg::ST_PAD;
        end
      end
      cs_pkg::ST_PAD:
      begin
        n.bi = 1'h0;
      end
      cs_pkg::ST_STACK:
      begin
        if (s.bus.wr)
          n.r.sp = s.r.sp - 16'h0001;
        if (s.cnt == `CYC_WAI_STACK - 5'h01)
          n.st = cs_pkg::ST_IDLE;
      end
      cs_pkg::ST_IDLE:
      begin
        if (IRQ_PEND)
        begin
          n.st = cs_pkg::ST_VEC;
          n.bi = 1'h0;
        end
      end
      cs_pkg::ST_VEC:
      begin
        if (!s.bi)
        begin
          n.r.pc[15:8] = MEM_RDATA;
          n.bi         = 1'h1;
        end
        else
        begin
          n.r.pc[7:0] = MEM_RDATA;
          n.bi        = 1'h0;
          n.st        = cs_pkg::ST_FETCH;
          n.cnt       = 5'h00;
          n.pre       = 1'h0;
        end
      end
      cs_pkg::ST_TEST:
      begin
        n.st = cs_pkg::ST_TEST;
      end
      default:
      begin
        n.st = cs_pkg::ST_FETCH;
      end
    endcase

    // Final cycle: commit the result
    if (fin)
    begin
      n.st  = cs_pkg::ST_FETCH;
      n.cnt = 5'h00;
      n.pre = 1'h0;
      unique case (s.dec.kind)
        cs_pkg::K_SUB_MEM_FROM_ACC_A:
        begin
          n.r.a   = alu_res[7:0];
          n.r.flag_register = alu_ccr;
        end
        cs_pkg::K_SUB_MEM_FROM_ACC_B:
        begin
          n.r.b   = alu_res[7:0];
          n.r.flag_register = alu_ccr;
        end
        cs_pkg::K_SUB_WORD_FROM_DOUBLE_ACC:
        begin
          {n.r.a, n.r.b} = alu_res;
          n.r.flag_register        = alu_ccr;
        end
        cs_pkg::K_TST, cs_pkg::K_ACC_A_SIGN_ZERO_CHECK, cs_pkg::K_ACC_B_SIGN_ZERO_CHECK:
          n.r.flag_register = alu_ccr;
        cs_pkg::K_TAP:
          n.r.flag_register = (s.r.a & ~`CC_X_MASK) | (s.r.a & s.r.flag_register & `CC_X_MASK);
        cs_pkg::K_TPA:
          n.r.a = s.r.flag_register;
        cs_pkg::K_TSX:
        begin
          if (s.pre)
            n.r.y = s.r.sp + 16'h0001;
          else
            n.r.x = s.r.sp + 16'h0001;
        end
        cs_pkg::K_TXS:
          n.r.sp = ixb - 16'h0001;
        default:
          n.r = s.r;
      endcase
    end

    // Bus request for the coming cycle
    n.bus.rd    = 1'h0;
    n.bus.wr    = 1'h0;
    n.bus.wdata = 8'h00;
    unique case (n.st)
      cs_pkg::ST_FETCH, cs_pkg::ST_ADDR:
      begin
        n.bus.addr = n.r.pc;
        n.bus.rd   = 1'h1;
      end
      cs_pkg::ST_DATA:
      begin
        n.bus.addr = (n.dec.mode == cs_pkg::M_IMM) ? n.r.pc : n.ea + {15'h0000, n.bi};
        n.bus.rd   = 1'h1;
      end
      cs_pkg::ST_STACK:
      begin
        if (n.cnt <= `WAI_PUSHES)
        begin
          n.bus.addr  = n.r.sp;
          n.bus.wr    = 1'h1;
          n.bus.wdata = push_byte(4'(n.cnt - 5'h01), n.r);
        end
      end
      cs_pkg::ST_VEC:
      begin
        n.bus.addr = IRQ_VECTOR + {15'h0000, n.bi};
        n.bus.rd   = 1'h1;
      end
      cs_pkg::ST_TEST:
        n.bus.addr = s.bus.addr + 16'h0001;
      default:
        n.bus.addr = s.bus.addr;
    endcase
    n.wt = (n.st == cs_pkg::ST_IDLE);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      s          <= '0;
      s.st       <= cs_pkg::ST_FETCH;
      s.r.flag_register    <= `CCR_RST;
      s.r.sp     <= `SP_RST;
      s.r.pc     <= `PC_RST;
      s.bus.addr <= `PC_RST;
      s.bus.rd   <= 1'h1;
    end
    else
      s <= n;
  end

  assign MEM_REQ    = s.bus;
  assign REGS       = s.r;
  assign WAITING    = s.wt;
  assign REL_TARGET = s.btgt;

  // ----------------------------------------------
  // Assertions
  // ----------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  sequence vec_fetch_q;
    s.st == cs_pkg::ST_VEC ##1 s.st == cs_pkg::ST_VEC ##1 s.st == cs_pkg::ST_FETCH;
  endsequence

  sub_mem_from_acc_a_result_a:
    assert property (fin && s.dec.kind == cs_pkg::K_SUB_MEM_FROM_ACC_A |=>
      s.r.a == 8'($past(s.r.a) - $past(opnd[7:0]))) else $error("A subtract wrong");
  sub_mem_from_acc_b_cycles_a:
    assert property (fin && s.dec.kind == cs_pkg::K_SUB_MEM_FROM_ACC_B && s.dec.mode == cs_pkg::M_DIR
      && !s.pre |-> s.cnt == 5'h02) else $error("B direct cycle count wrong");
  sub_keeps_hi_a:
    assert property (fin && s.dec.kind inside {cs_pkg::K_SUB_MEM_FROM_ACC_A, cs_pkg::K_SUB_MEM_FROM_ACC_B} |=>
      $stable(s.r.flag_register[5:4])) else $error("H or I changed by subtract");
  sub_word_from_double_acc_result_a:
    assert property (fin && s.dec.kind == cs_pkg::K_SUB_WORD_FROM_DOUBLE_ACC |=>
      {s.r.a, s.r.b} == 16'($past({s.r.a, s.r.b}) - $past(opnd))) else $error("D wrong");
  x_clear_only_a:
    assert property (!$rose(s.r.flag_register[`CC_X])) else $error("X mask bit raised");
  tpa_copy_a:
    assert property (fin && s.dec.kind == cs_pkg::K_TPA |=>
      s.r.a == $past(s.r.flag_register) && $stable(s.r.flag_register)) else $error("flags to A wrong");
  test_run_a:
    assert property (s.st == cs_pkg::ST_TEST |=> s.st == cs_pkg::ST_TEST
      && s.bus.addr == 16'($past(s.bus.addr) + 16'h0001)) else $error("test run broken");
  tst_clears_a:
    assert property (fin && s.dec.kind inside {cs_pkg::K_TST, cs_pkg::K_ACC_A_SIGN_ZERO_CHECK,
      cs_pkg::K_ACC_B_SIGN_ZERO_CHECK} |=> s.r.flag_register[1:0] == 2'h0) else $error("V or C not cleared");
  tsx_load_a:
    assert property (fin && s.dec.kind == cs_pkg::K_TSX |=> ($past(s.pre) ? s.r.y : s.r.x)
      == 16'($past(s.r.sp) + 16'h0001)) else $error("index load wrong");
  txs_load_a:
    assert property (fin && s.dec.kind == cs_pkg::K_TXS |=>
      s.r.sp == 16'($past(ixb) - 16'h0001)) else $error("stack load wrong");
  wai_stack_a:
    assert property ($rose(s.st == cs_pkg::ST_STACK) |-> ##11 s.st == cs_pkg::ST_IDLE)
      else $error("stacking length wrong");
  wai_vector_a:
    assert property (s.st == cs_pkg::ST_IDLE && IRQ_PEND |=> vec_fetch_q)
      else $error("vector fetch wrong");
  dir_page_a:
    assert property (s.st == cs_pkg::ST_DATA && s.dec.mode == cs_pkg::M_DIR
      |-> s.bus.addr[15:8] == 8'h00) else $error("direct page not zero");

endmodule // cpu_subtract_test_transfer_ops

// >>> hdl/cs_pkg.sv
package cs_pkg;

  typedef enum logic [7:0] {
    ST_FETCH = 8'h01,
    ST_ADDR  = 8'h02,
    ST_DATA  = 8'h04,
    ST_PAD   = 8'h08,
    ST_STACK = 8'h10,
    ST_IDLE  = 8'h20,
    ST_VEC   = 8'h40,
    ST_TEST  = 8'h80
  } state_e;

  typedef enum logic [3:0] {
    K_NOP, K_SUB_MEM_FROM_ACC_A, K_SUB_MEM_FROM_ACC_B, K_SUB_WORD_FROM_DOUBLE_ACC, K_TAP, K_TPA, K_TEST,
    K_TST, K_ACC_A_SIGN_ZERO_CHECK, K_ACC_B_SIGN_ZERO_CHECK, K_TSX, K_TXS, K_WAI
  } kind_e;

  typedef enum logic [1:0] {M_IMM, M_DIR, M_IDX, M_EXT} mode_e;

  typedef enum logic [1:0] {ALU_SUB8, ALU_SUB16, ALU_TEST8} alu_op_e;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } mem_req_s;

  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  flag_register;
  } regs_s;

  typedef struct packed {
    kind_e      kind;
    mode_e      mode;
    logic [4:0] tot;
  } dec_s;

  typedef struct packed {
    state_e      st;
    logic [4:0]  cnt;
    dec_s        dec;
    logic        pre;
    logic        bi;
    logic [15:0] ea;
    logic [15:0] dat;
    regs_s       r;
    mem_req_s    bus;
    logic        wt;
    logic [15:0] btgt;
  } core_s;

endpackage

// >>> hdl/sub_test_alu.sv
`timescale 1ns/100ps
`include "cpu_slice_defines.svh"
module sub_test_alu (
  input  wire cs_pkg::alu_op_e op,
  input  wire logic [15:0]     lhs,
  input  wire logic [15:0]     rhs,
  input  wire logic [7:0]      ccr_in,
  output logic [15:0]          res,
  output logic [7:0]           ccr_out
);

  logic [8:0]  d8;
  logic [16:0] d16;

  assign d8  = {1'h0, lhs[7:0]} - {1'h0, rhs[7:0]};
  assign d16 = {1'h0, lhs} - {1'h0, rhs};

  // H, I, S and X always pass through
  always_comb
  begin
    res     = lhs;
    ccr_out = ccr_in;
    unique case (op)
      cs_pkg::ALU_SUB8:
      begin
        res               = {8'h00, d8[7:0]};
        ccr_out[`CC_N]    = d8[7];
        ccr_out[`CC_Z]    = (d8[7:0] == 8'h00);
        ccr_out[`CC_V]    = (lhs[7] ^ rhs[7]) & (lhs[7] ^ d8[7]);
        ccr_out[`CC_C]    = d8[8];
      end
      cs_pkg::ALU_SUB16:
      begin
        res               = d16[15:0];
        ccr_out[`CC_N]    = d16[15];
        ccr_out[`CC_Z]    = (d16[15:0] == 16'h0000);
        ccr_out[`CC_V]    = (lhs[15] ^ rhs[15]) & (lhs[15] ^ d16[15]);
        ccr_out[`CC_C]    = d16[16];
      end
      cs_pkg::ALU_TEST8:
      begin
        ccr_out[`CC_N]    = lhs[7];
        ccr_out[`CC_Z]    = (lhs[7:0] == 8'h00);
        ccr_out[`CC_V]    = 1'h0;
        ccr_out[`CC_C]    = 1'h0;
      end
      default:
      begin
        res     = lhs;
        ccr_out = ccr_in;
      end
    endcase
  end

endmodule // sub_test_alu

// >>> test/cpu_subtract_test_transfer_ops_tb.sv
`timescale 1ns/100ps
module cpu_subtract_test_transfer_ops_tb;
  typedef struct {int cyc; logic [71:0] r; logic [15:0] pc;} note_s;
  logic             CORE_CLK   = 1'b0;
  logic             SRST       = 1'b1;
  logic             TEST_MODE  = 1'b0;
  logic             IRQ_PEND   = 1'b0;
  logic [15:0]      IRQ_VECTOR = 16'h3100;
  logic [7:0]       MEM_RDATA;
  cs_pkg::mem_req_s MEM_REQ;
  cs_pkg::regs_s    REGS;
  logic             WAITING;
  note_s            q [$];
  int               num_errors = 0;
  int               n_compared = 0;
  int               cyc = 0;
  int               t_m = 0;
  int               t_test;
  int               nwait;
  logic [15:0]      pc_m = 16'h0000;
  logic [15:0]      mx = 16'h0000;
  logic [15:0]      my = 16'h0000;
  logic [15:0]      msp = 16'h00FF;
  logic [15:0]      prev;
  logic [7:0]       ma = 8'h00;
  logic [7:0]       mb = 8'h00;
  logic [7:0]       mcc = 8'hD0;
  logic [7:0]       stk [0:8];

  cpu_subtract_test_transfer_ops u_dut (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .MEM_RDATA(MEM_RDATA), .TEST_MODE(TEST_MODE), .IRQ_PEND(IRQ_PEND),
    .IRQ_VECTOR(IRQ_VECTOR), .MEM_REQ(MEM_REQ), .REGS(REGS), .WAITING(WAITING),
    .REL_TARGET());
  mem_partner u_mem (.clk(CORE_CLK), .req(MEM_REQ), .rdata(MEM_RDATA));

  initial forever #50 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) cyc <= SRST ? 0 : cyc + 1;

  // ----------------------------------------------
  // Checking and verdict
  // ----------------------------------------------
  task automatic check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------
  // Reference model and program builder
  // ----------------------------------------------
  function automatic logic [15:0] sub_ref(input logic [15:0] l, input logic [15:0] r,
                                          input bit w, inout logic [7:0] cc);
    logic [16:0] d;
    if (!w)
    begin
      l = {l[7:0], 8'h00};
      r = {r[7:0], 8'h00};
    end
    d = {1'b0, l} - {1'b0, r};
    cc[3:0] = {d[15], d[15:0] == 16'h0000, (l[15] ^ r[15]) & (l[15] ^ d[15]), d[16]};
    return w ? d[15:0] : {8'h00, d[15:8]};
  endfunction

  task automatic put(input logic [7:0] v);
    u_mem.poke(pc_m, v);
    pc_m = pc_m + 16'h0001;
  endtask

  task automatic fin(input int c);
    t_m = t_m + c;
    q.push_back('{t_m, {ma, mb, mx, my, msp, mcc}, pc_m});
  endtask

  function automatic logic [15:0] pick(input logic [15:0] base, input int span, input bit w);
    logic [15:0] a;
    do
      a = base + 16'($urandom % span);
    while (u_mem.vld[a] || (w && u_mem.vld[a + 16'h0001]));
    return a;
  endfunction

  // Operand bytes for one addressing mode, data placed where it is read
  task automatic opnd(input int md, input bit w, output logic [15:0] v);
    logic [15:0] ad;
    v = 16'($urandom);
    if (!w)
      v[15:8] = 8'h00;
    if (md == 0)
    begin
      if (w)
        put(v[15:8]);
      put(v[7:0]);
      return;
    end
    ad = pick(md == 1 ? 16'h00C0 : md == 2 ? 16'h3000 : md == 3 ? mx
              : (my == 16'h0000 ? 16'h00C0 : my), (md == 2 || md == 3) ? 256 : 46, w);
    if (md == 2)
      put(ad[15:8]);
    put(md == 3 ? 8'(ad - mx) : md == 4 ? 8'(ad - my) : ad[7:0]);
    u_mem.poke(ad, w ? v[15:8] : v[7:0]);
    if (w)
      u_mem.poke(ad + 16'h0001, v[7:0]);
  endtask

  task automatic sub_op(input int acc, input int md);
    logic [15:0] v;
    logic [15:0] r;
    logic [7:0]  moff [5] = '{8'h00, 8'h10, 8'h30, 8'h20, 8'h20};
    if (md == 4)
      put(8'h18);
    put((acc == 0 ? 8'h80 : acc == 1 ? 8'hC0 : 8'h83) + moff[md]);
    opnd(md, acc == 2, v);
    r = sub_ref(acc == 2 ? {ma, mb} : {8'h00, acc == 0 ? ma : mb}, v, acc == 2, mcc);
    if (acc == 0)
      ma = r[7:0];
    else if (acc == 1)
      mb = r[7:0];
    else
      {ma, mb} = r;
    fin((acc == 2 ? 4 : 2) + (md == 0 ? 0 : md == 1 ? 1 : md == 4 ? 3 : 2));
  endtask

  task automatic tst_op(input int md);
    logic [15:0] v;
    if (md == 4)
      put(8'h18);
    put(md == 2 ? 8'h7D : 8'h6D);
    opnd(md, 1'b0, v);
    v = sub_ref(v, 16'h0000, 1'b0, mcc);
    fin(md == 4 ? 7 : 6);
  endtask

  task automatic set_a(input logic [7:0] t);
    logic [15:0] r;
    put(8'h80);
    put(ma - t);
    r = sub_ref({8'h00, ma}, {8'h00, ma - t}, 1'b0, mcc);
    ma = r[7:0];
    fin(2);
  endtask

  task automatic acc_test(input bit b);
    logic [15:0] r;
    put(b ? 8'h5D : 8'h4D);
    r = sub_ref({8'h00, b ? mb : ma}, 16'h0000, 1'b0, mcc);
    fin(2);
  endtask

  task automatic flags_io();
    put(8'h06);
    mcc = (ma & 8'hBF) | (ma & mcc & 8'h40);
    fin(2);
    put(8'h07);
    ma = mcc;
    fin(2);
  endtask

  // ----------------------------------------------
  // Result watcher
  // ----------------------------------------------
  always @(negedge CORE_CLK)
    if (!SRST && q.size() > 0 && q[0].cyc == cyc)
    begin
      check("regs", {REGS.a, REGS.b, REGS.x, REGS.y, REGS.sp, REGS.flag_register}, q[0].r);
      check("fetch", {MEM_REQ.rd, MEM_REQ.addr}, {1'b1, q[0].pc});
      void'(q.pop_front());
    end

  initial
  begin
    @(negedge CORE_CLK iff WAITING === 1'b1);
    repeat (nwait - 1) @(negedge CORE_CLK);
    IRQ_PEND = 1'b1;
    @(negedge CORE_CLK iff WAITING === 1'b0);
    IRQ_PEND = 1'b0;
  end

  initial
  begin
    #(3000 * 100);
    num_errors++;
    summarize();
  end

  // ----------------------------------------------
  // Main sequence
  // ----------------------------------------------
  initial
  begin
    void'($urandom(20542));
    nwait = 1 + $urandom % 8;
    u_mem.poke(16'h3100, 8'h04);
    u_mem.poke(16'h3101, 8'h00);
    put(8'h30);
    mx = msp + 16'h0001;
    fin(3);
    put(8'h00);
    fin(2);
    for (int rd = 0; rd < 2; rd++)
      for (int acc = 0; acc < 3; acc++)
        for (int md = 0; md < 5; md++)
          sub_op(acc, md);
    for (int md = 2; md < 5; md++)
      tst_op(md);
    acc_test(1'b1);
    set_a(8'h00);
    acc_test(1'b0);
    set_a(8'h80);
    acc_test(1'b0);
    set_a(8'($urandom) & 8'hBF);
    flags_io();
    set_a(8'($urandom) | 8'h40);
    flags_io();
    put(8'h18);
    put(8'h30);
    my = msp + 16'h0001;
    fin(4);
    put(8'h35);
    msp = mx - 16'h0001;
    fin(3);
    put(8'h18);
    put(8'h35);
    msp = my - 16'h0001;
    fin(4);
    put(8'h3E);
    stk = '{pc_m[7:0], pc_m[15:8], my[7:0], my[15:8], mx[7:0], mx[15:8], ma, mb, mcc};
    msp = msp - 16'h0009;
    pc_m = 16'h0400;
    fin(14 + nwait);
    set_a(8'($urandom));
    acc_test(1'b0);
    t_test = t_m;
    put(8'h00);
    repeat (5) @(negedge CORE_CLK);
    SRST = 1'b0;
    do
      @(negedge CORE_CLK);
    while (cyc != t_test - 1);
    TEST_MODE = 1'b1;
    repeat (2) @(negedge CORE_CLK);
    prev = MEM_REQ.addr;
    repeat (20)
    begin
      @(negedge CORE_CLK);
      check("test addr", {MEM_REQ.rd, MEM_REQ.wr, MEM_REQ.addr}, {2'b00, prev + 16'h0001});
      prev = MEM_REQ.addr;
    end
    check("test regs", {REGS.a, REGS.b, REGS.x, REGS.y, REGS.sp, REGS.flag_register},
          {ma, mb, mx, my, msp, mcc});
    check("notes left", 80'(q.size()), 80'(0));
    for (int k = 0; k < 9; k++)
      check("stack", u_mem.m[16'h00FF - 16'(k)], stk[k]);
    SRST = 1'b1;
    repeat (2) @(negedge CORE_CLK);
    check("reset", {WAITING, MEM_REQ.rd, MEM_REQ.addr, REGS.sp, REGS.flag_register},
          {1'b0, 1'b1, 16'h0000, 16'h00FF, 8'hD0});
    summarize();
  end
endmodule // cpu_subtract_test_transfer_ops_tb

// >>> test/mem_partner.sv
`timescale 1ns/100ps
module mem_partner (
  input  wire logic             clk,
  input  wire cs_pkg::mem_req_s req,
  output logic [7:0]            rdata
);
  logic [7:0] m   [0:65535];
  bit         vld [0:65535];
  logic       flip_r = 1'b0;

  // Unwritten places give a pattern that changes every cycle
  assign rdata = vld[req.addr] ? m[req.addr] : (req.addr[7:0] ^ {8{flip_r}});

  always @(posedge clk)
  begin
    flip_r <= ~flip_r;
    if (req.wr)
    begin
      m[req.addr]   <= req.wdata;
      vld[req.addr] <= 1'b1;
    end
  end

  task automatic poke(input logic [15:0] a, input logic [7:0] v);
    m[a]   = v;
    vld[a] = 1'b1;
  endtask
endmodule // mem_partner
